// ==== rtl/cis_defs.svh ====
// Constants for the interrupt entry and exit sequencer.
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH
`define CIS_PC_W 12
`define CIS_SP_W 16
`define CIS_NSRC 8
`define CIS_GIE_BIT 7
`define CIS_RESET_VEC 12'h000
`define CIS_VEC_STEP 12'h001
`define CIS_VEC_BASE 12'h001
`define CIS_BOOT_START 12'hC00
`define CIS_SP_RESET 16'h0000
`define CIS_STATUS_RESET 8'h00
`define CIS_ENTRY_CYC 3'h4
`define CIS_WAKE_CYC 3'h4
`define CIS_RETURN_CYC 3'h4
`define CIS_SP_STEP 16'h0002
`endif

// ==== rtl/cis_pkg.sv ====
// Types for the interrupt entry and exit sequencer.
package cis_pkg;
    typedef enum logic [2:0] {CIS_RUN, CIS_WAKE, CIS_ENTRY, CIS_RETURN, CIS_HOLD} cis_state_t;
endpackage

// ==== rtl/cis_sequencer.sv ====
// Interrupt entry, arbitration and return sequencer for an 8-bit core.
// Summary of operation
// - Reset and each source own a distinct vector loaded into the counter.
// - A source is served only when its enable and global enable are set.
// - Lock bits suppress interrupts depending on the current counter section.
// - Lowest vector address wins among pending requests; reset ranks above all.
// - Vector select moves the interrupt table to the boot section start.
// - Accepting an interrupt clears the global enable bit.
// - Global enable set inside a handler lets enabled requests nest.
// - Return from interrupt sets the global enable bit.
// - Latched flags are cleared by hardware when their vector is taken.
// - Writing one clears a flag; writing zero leaves it.
// - Events set flags even when disabled; flags stay pending.
// - Flags pending while globally disabled are served later by priority.
// - Level sources request only while their condition is present.
// - One program instruction runs after return before another interrupt.
// - Status register is neither saved nor restored by hardware.
// - Global disable acts at once, even against a same-cycle request.
// - The instruction after global enable runs before any interrupt.
// - Entry takes four cycles pushing the counter, then jumps to vector.
// - A multi-cycle instruction completes before entry begins.
// - Waking from sleep adds four cycles to the response.
// - Return takes four cycles, pops two bytes, adds two to stack pointer.
// - Counter and vector addresses are 12 bits wide.
// - Global enable is bit 7 of the processor status register.
// - Entry push lowers the stack pointer by two.
`timescale 1ns/10ps
`include "cis_defs.svh"
module cis_sequencer
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`CIS_NSRC-1:0] src_event,
    input wire logic [`CIS_NSRC-1:0] src_level,
    input wire logic [`CIS_NSRC-1:0] src_is_level,
    input wire logic [`CIS_NSRC-1:0] src_enable,
    input wire logic [`CIS_NSRC-1:0] flag_clear_wr,
    input wire logic instr_done,
    input wire logic [`CIS_PC_W-1:0] next_pc,
    input wire logic sleeping,
    input wire logic set_gie_instr,
    input wire logic clr_gie_instr,
    input wire logic return_from_interrupt_instr,
    input wire logic status_wr,
    input wire logic [7:0] status_wdata,
    input wire logic [`CIS_PC_W-1:0] popped_pc,
    input wire logic vector_table_select,
    input wire logic reset_vector_relocate_fuse,
    input wire logic app_section_lock_bit,
    input wire logic boot_section_lock_bit,
    output logic [`CIS_PC_W-1:0] program_counter,
    output logic [7:0] processor_status_reg,
    output logic [`CIS_SP_W-1:0] stack_pointer,
    output logic [`CIS_NSRC-1:0] flag_out,
    output logic cpu_stall,
    output logic push_strobe,
    output logic [`CIS_PC_W-1:0] push_pc,
    output logic pop_strobe,
    output logic [2:0] served_src,
    output logic serve_active
);
    import cis_pkg::*;

    // Request vector address of a source index, with optional relocation to the boot section.
    function automatic logic [`CIS_PC_W-1:0] vec_addr(input logic [2:0] idx, input logic relocate);
        logic [`CIS_PC_W-1:0] base;
        base = relocate ? `CIS_BOOT_START : 12'h000;
        vec_addr = base + `CIS_VEC_BASE + {9'h000, idx} * `CIS_VEC_STEP;
    endfunction

    // Index of the lowest-numbered set bit; the lowest index has the lowest vector.
    function automatic logic [2:0] first_set(input logic [`CIS_NSRC-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = `CIS_NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = i[2:0];
            end
        end
        first_set = r;
    endfunction

    cis_state_t state_reg;
    logic [2:0] cnt_reg;
    logic [`CIS_NSRC-1:0] flag_reg;
    logic [`CIS_NSRC-1:0] flag_next;
    logic skip_one_reg;
    logic in_boot;
    logic lock_block;
    logic [`CIS_NSRC-1:0] pend;
    logic [`CIS_NSRC-1:0] eligible;
    logic gie_now;
    logic take;
    logic [2:0] win;
    logic reset_seen_reg;
    logic [`CIS_PC_W-1:0] held_pc_reg;

    // Lock bits protect the section the program is running from; a handler in the
    // other section could otherwise read or patch protected code.
    assign in_boot = next_pc >= `CIS_BOOT_START;
    assign lock_block = in_boot ? (vector_table_select == 1'b0 && boot_section_lock_bit)
                                : (vector_table_select == 1'b1 && app_section_lock_bit);

    // Level sources bypass the flag and request only while present.
    assign pend = (flag_reg & ~src_is_level) | (src_level & src_is_level);
    assign eligible = pend & src_enable;
    // A same-cycle disable wins, so no request slips through behind it.
    assign gie_now = processor_status_reg[`CIS_GIE_BIT] && !clr_gie_instr;
    assign take = state_reg == CIS_RUN && instr_done && gie_now && !skip_one_reg
                  && !set_gie_instr && !return_from_interrupt_instr && |eligible && !lock_block;
    assign win = first_set(eligible);

    // Flags: set beats both clears so an event landing with a clear is not lost.
    always_comb
    begin
        flag_next = flag_reg;
        for (int i = 0; i < `CIS_NSRC; i++)
        begin
            if (flag_clear_wr[i])
            begin
                flag_next[i] = 1'b0;
            end
            if (take && win == i[2:0] && !src_is_level[i])
            begin
                flag_next[i] = 1'b0;
            end
            if (src_event[i] && !src_is_level[i])
            begin
                flag_next[i] = 1'b1;
            end
        end
    end

    // Flag storage.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            flag_reg <= {`CIS_NSRC{1'b0}};
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;

    // Sequencer: entry, wake extension, return and post-return hold.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg <= CIS_RUN;
            cnt_reg <= 3'h0;
            served_src <= 3'h0;
            held_pc_reg <= 12'h000;
        end
        else
        begin
            unique case (state_reg)
                CIS_RUN:
                begin
                    if (take)
                    begin
                        served_src <= win;
                        held_pc_reg <= next_pc;
                        cnt_reg <= 3'h1;
                        state_reg <= sleeping ? CIS_WAKE : CIS_ENTRY;
                    end
                    else if (instr_done && return_from_interrupt_instr)
                    begin
                        cnt_reg <= 3'h1;
                        state_reg <= CIS_RETURN;
                    end
                end
                CIS_WAKE:
                begin
                    cnt_reg <= (cnt_reg == `CIS_WAKE_CYC) ? 3'h1 : cnt_reg + 3'h1;
                    if (cnt_reg == `CIS_WAKE_CYC)
                    begin
                        state_reg <= CIS_ENTRY;
                    end
                end
                CIS_ENTRY:
                begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == `CIS_ENTRY_CYC)
                    begin
                        state_reg <= CIS_RUN;
                    end
                end
                CIS_RETURN:
                begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == `CIS_RETURN_CYC)
                    begin
                        state_reg <= CIS_HOLD;
                    end
                end
                CIS_HOLD:
                begin
                    state_reg <= CIS_RUN;
                end
            endcase
        end
    end

    // Outputs registered from the sequencer state.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cpu_stall <= 1'b0;
            serve_active <= 1'b0;
            push_strobe <= 1'b0;
            push_pc <= 12'h000;
            pop_strobe <= 1'b0;
        end
        else
        begin
            cpu_stall <= take || (state_reg == CIS_WAKE) || (state_reg == CIS_ENTRY && cnt_reg != `CIS_ENTRY_CYC)
                         || (state_reg == CIS_RUN && instr_done && return_from_interrupt_instr)
                         || (state_reg == CIS_RETURN && cnt_reg != `CIS_RETURN_CYC);
            serve_active <= take;
            push_strobe <= state_reg == CIS_ENTRY && cnt_reg == 3'h1;
            push_pc <= held_pc_reg;
            pop_strobe <= state_reg == CIS_RETURN && cnt_reg == 3'h1;
        end
    end

    // Skip-one guard: after a return, and after global enable, one instruction runs.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            skip_one_reg <= 1'b0;
        end
        else if (state_reg == CIS_HOLD || (instr_done && set_gie_instr))
        begin
            skip_one_reg <= 1'b1;
        end
        else if (instr_done)
        begin
            skip_one_reg <= 1'b0;
        end
    end

    // Status register: only the global enable is touched by hardware; the other
    // bits are never saved or restored around a handler.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            processor_status_reg <= `CIS_STATUS_RESET;
        end
        else
        begin
            if (status_wr)
            begin
                processor_status_reg <= status_wdata;
            end
            if (instr_done && set_gie_instr)
            begin
                processor_status_reg[`CIS_GIE_BIT] <= 1'b1;
            end
            if (clr_gie_instr)
            begin
                processor_status_reg[`CIS_GIE_BIT] <= 1'b0;
            end
            if (take)
            begin
                processor_status_reg[`CIS_GIE_BIT] <= 1'b0;
            end
            if (state_reg == CIS_RETURN && cnt_reg == `CIS_RETURN_CYC)
            begin
                processor_status_reg[`CIS_GIE_BIT] <= 1'b1;
            end
        end
    end

    // Stack pointer moves two bytes for each push or pop of the counter.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            stack_pointer <= `CIS_SP_RESET;
        end
        else if (state_reg == CIS_ENTRY && cnt_reg == 3'h1)
        begin
            stack_pointer <= stack_pointer - `CIS_SP_STEP;
        end
        else if (state_reg == CIS_RETURN && cnt_reg == 3'h1)
        begin
            stack_pointer <= stack_pointer + `CIS_SP_STEP;
        end
    end

    // Program counter: reset vector first, then vectors and returns.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            program_counter <= `CIS_RESET_VEC;
            reset_seen_reg <= 1'b0;
        end
        else
        begin
            reset_seen_reg <= 1'b1;
            if (!reset_seen_reg)
            begin
                program_counter <= reset_vector_relocate_fuse ? `CIS_BOOT_START : `CIS_RESET_VEC;
            end
            else if (state_reg == CIS_ENTRY && cnt_reg == `CIS_ENTRY_CYC)
            begin
                program_counter <= vec_addr(served_src, vector_table_select);
            end
            else if (state_reg == CIS_RETURN && cnt_reg == `CIS_RETURN_CYC)
            begin
                program_counter <= popped_pc;
            end
            else if (state_reg == CIS_RUN && !take)
            begin
                program_counter <= next_pc;
            end
        end
    end

    // Entry lasts exactly four cycles once begun.
    property p_entry_len;
        @(posedge clock) disable iff (!nrst)
        $rose(state_reg == CIS_ENTRY) |-> (state_reg == CIS_ENTRY) [*4] ##1 state_reg != CIS_ENTRY;
    endproperty
    AST_ENTRY_LEN: assert property (p_entry_len) else $error("entry length wrong");

    AST_GIE_CLEARED: assert property (@(posedge clock) disable iff (!nrst)
        take |=> !processor_status_reg[`CIS_GIE_BIT]) else $error("gie not cleared on entry");
    AST_RETURN_GIE: assert property (@(posedge clock) disable iff (!nrst)
        (state_reg == CIS_RETURN && cnt_reg == `CIS_RETURN_CYC) |=> processor_status_reg[`CIS_GIE_BIT])
        else $error("gie not set on return");
    AST_NO_TAKE_CLI: assert property (@(posedge clock) disable iff (!nrst)
        clr_gie_instr |-> !take) else $error("taken during disable");
    AST_SP_PUSH: assert property (@(posedge clock) disable iff (!nrst)
        push_strobe |-> stack_pointer == $past(stack_pointer) - `CIS_SP_STEP) else $error("sp push step");
    AST_SP_POP: assert property (@(posedge clock) disable iff (!nrst)
        pop_strobe |-> stack_pointer == $past(stack_pointer) + `CIS_SP_STEP) else $error("sp pop step");
    AST_HOLD_ONE: assert property (@(posedge clock) disable iff (!nrst)
        state_reg == CIS_HOLD |=> !take) else $error("no instruction after return");
    AST_FLAG_CLR: assert property (@(posedge clock) disable iff (!nrst)
        (take && !src_is_level[win] && !src_event[win]) |=> !flag_reg[$past(win)])
        else $error("flag not cleared on vector");
    AST_ENABLED: assert property (@(posedge clock) disable iff (!nrst)
        take |-> src_enable[win] && processor_status_reg[`CIS_GIE_BIT]) else $error("served while disabled");
    sequence s_wake;
        state_reg == CIS_WAKE [*4];
    endsequence
    AST_WAKE: assert property (@(posedge clock) disable iff (!nrst)
        (take && sleeping) |=> s_wake ##1 state_reg == CIS_ENTRY) else $error("wake extension wrong");
endmodule

// ==== tb/cis_stack_model.sv ====
// Behavioural return-address stack standing beside the sequencer.
`timescale 1ns/10ps
`include "cis_defs.svh"
module cis_stack_model
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic push_strobe,
    input wire logic [`CIS_PC_W-1:0] push_pc,
    input wire logic pop_strobe,
    input wire logic ret_start,
    output logic [`CIS_PC_W-1:0] popped_pc
);
    logic [`CIS_PC_W-1:0] mem_reg [0:15];
    logic [4:0] depth_reg;
    logic pend_reg;
    logic [`CIS_PC_W-1:0] last_reg;
    logic [4:0] base_w;

    // A pending pop is only committed by the next push or return start.
    assign base_w = depth_reg - {4'h0, pend_reg};

    // A popped word stays on the read port until the next stack access, so the sequencer may take it late.
    // An empty stack shows the inverse of the last word, since nothing drives the read port then.
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            depth_reg <= 5'h00;
            pend_reg <= 1'b0;
            last_reg <= 12'h000;
        end
        else if (pop_strobe)
        begin
            pend_reg <= 1'b1;
            last_reg <= popped_pc;
        end
        else if (push_strobe)
        begin
            mem_reg[base_w[3:0]] <= push_pc;
            depth_reg <= base_w + 5'h01;
            pend_reg <= 1'b0;
        end
        else if (ret_start && pend_reg)
        begin
            depth_reg <= base_w;
            pend_reg <= 1'b0;
        end
    end

    assign popped_pc = (depth_reg == 5'h00) ? ~last_reg : mem_reg[depth_reg[3:0] - 4'h1];
endmodule

// ==== tb/cis_sequencer_bench.sv ====
// Self-checking bench for the interrupt entry and exit sequencer.
`timescale 1ns/10ps
`include "cis_defs.svh"
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module cis_sequencer_bench;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] src_event = 8'h00, src_level = 8'h00, src_is_level = 8'h00, src_enable = 8'h00;
    logic [7:0] flag_clear_wr = 8'h00, status_wdata = 8'h00, processor_status_reg, flag_out;
    logic instr_done = 1'b0, sleeping = 1'b0, set_gie_instr = 1'b0, clr_gie_instr = 1'b0;
    logic return_from_interrupt_instr = 1'b0, status_wr = 1'b0, vector_table_select = 1'b0;
    logic reset_vector_relocate_fuse = 1'b0, app_section_lock_bit = 1'b0, boot_section_lock_bit = 1'b0;
    logic [11:0] next_pc = 12'h000, popped_pc, program_counter, push_pc;
    logic [15:0] stack_pointer;
    logic cpu_stall, push_strobe, pop_strobe, serve_active;
    logic [2:0] served_src;
    int err_total = 0;
    int comparisons = 0;

    always #2 clock = ~clock;

    cis_sequencer dut (.clock, .nrst, .src_event, .src_level, .src_is_level, .src_enable, .flag_clear_wr,
        .instr_done, .next_pc, .sleeping, .set_gie_instr, .clr_gie_instr, .return_from_interrupt_instr,
        .status_wr, .status_wdata, .popped_pc, .vector_table_select, .reset_vector_relocate_fuse,
        .app_section_lock_bit, .boot_section_lock_bit, .program_counter, .processor_status_reg,
        .stack_pointer, .flag_out, .cpu_stall, .push_strobe, .push_pc, .pop_strobe, .served_src, .serve_active);

    cis_stack_model stack (.clock, .nrst, .push_strobe, .push_pc, .pop_strobe,
        .ret_start(instr_done & return_from_interrupt_instr), .popped_pc);

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One-cycle pulses of events, flag clears and a status write.
    task automatic drive(input logic [7:0] ev, input logic [7:0] clr, input logic wr, input logic [7:0] wd);
        @(negedge clock);
        {src_event, flag_clear_wr, status_wr, status_wdata} = {ev, clr, wr, wd};
        @(negedge clock);
        {src_event, flag_clear_wr, status_wr} = 17'h00000;
    endtask

    // One instruction boundary; ops are sleep, return, enable and disable, sent with the boundary.
    task automatic step(input logic [3:0] ops, input logic [7:0] ev, input logic [11:0] npc, input logic svd,
        input logic [2:0] idx, input logic [11:0] vec, input int cyc);
        @(negedge clock);
        {sleeping, return_from_interrupt_instr, set_gie_instr, clr_gie_instr} = ops;
        {instr_done, next_pc, src_event} = {1'b1, npc, ev};
        @(negedge clock);
        `CHK("serve_active", svd, serve_active)
        `CHK("cpu_stall", svd | ops[2], cpu_stall)
        {sleeping, return_from_interrupt_instr, set_gie_instr, clr_gie_instr} = 4'h0;
        {instr_done, src_event} = 9'h000;
        if (svd)
        begin
            `CHK("served_src", idx, served_src)
            repeat (cyc - 1) @(negedge clock);
            `CHK("vector pc", vec, program_counter)
            `CHK("stall released", 1'b0, cpu_stall)
        end
    endtask

    // Return, then one plain boundary that must not be interrupted.
    task automatic ret(input logic [11:0] epc, input logic [15:0] esp);
        step(4'h4, 8'h00, 12'h000, 1'b0, 3'h0, 12'h000, 0);
        repeat (4) @(negedge clock);
        `CHK("return pc", epc, program_counter)
        `CHK("return stall", 1'b0, cpu_stall)
        `CHK("return sp", esp, stack_pointer)
        `CHK("return status", 8'hA5, processor_status_reg)
        step(4'h0, 8'h00, epc + 12'h001, 1'b0, 3'h0, 12'h000, 0);
    endtask

    // The tests need well under a thousand cycles; five thousand leaves ample margin.
    initial
    begin
        #20000;
        err_total++;
        wrap_up();
    end

    initial
    begin
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        `CHK("reset pc", 12'h000, program_counter)
        `CHK("reset sp", 16'h0000, stack_pointer)
        drive(8'h00, 8'h00, 1'b1, 8'h25);
        drive(8'h0A, 8'h00, 1'b0, 8'h00);
        `CHK("flags while disabled", 8'h0A, flag_out)
        step(4'h0, 8'h00, 12'h100, 1'b0, 3'h0, 12'h000, 0);
        src_enable = 8'hFF;
        step(4'h0, 8'h00, 12'h101, 1'b0, 3'h0, 12'h000, 0);
        step(4'h2, 8'h00, 12'h102, 1'b0, 3'h0, 12'h000, 0);
        `CHK("status after enable", 8'hA5, processor_status_reg)
        step(4'h0, 8'h00, 12'h103, 1'b0, 3'h0, 12'h000, 0);
        step(4'h0, 8'h00, 12'h123, 1'b1, 3'h1, 12'h002, 5);
        `CHK("status after entry", 8'h25, processor_status_reg)
        `CHK("sp after entry", 16'hFFFE, stack_pointer)
        `CHK("flag after vector", 8'h08, flag_out)
        `CHK("pushed pc", 12'h123, popped_pc)
        step(4'h2, 8'h00, 12'h00F, 1'b0, 3'h0, 12'h000, 0);
        step(4'h0, 8'h00, 12'h00F, 1'b0, 3'h0, 12'h000, 0);
        step(4'h0, 8'h00, 12'h010, 1'b1, 3'h3, 12'h004, 5);
        `CHK("nested sp", 16'hFFFC, stack_pointer)
        drive(8'h01, 8'h00, 1'b0, 8'h00);
        ret(12'h010, 16'hFFFE);
        step(4'h0, 8'h00, 12'h020, 1'b1, 3'h0, 12'h001, 5);
        ret(12'h020, 16'hFFFE);
        ret(12'h123, 16'h0000);
        drive(8'h44, 8'h00, 1'b0, 8'h00);
        step(4'h1, 8'h44, 12'h130, 1'b0, 3'h0, 12'h000, 0);
        `CHK("status after disable", 8'h25, processor_status_reg)
        drive(8'h00, 8'h04, 1'b0, 8'h00);
        `CHK("flags after clear", 8'h40, flag_out)
        drive(8'h00, 8'h40, 1'b0, 8'h00);
        `CHK("flags cleared", 8'h00, flag_out)
        src_is_level = 8'h20;
        src_level = 8'h20;
        @(negedge clock);
        src_level = 8'h00;
        drive(8'h00, 8'h00, 1'b1, 8'hA5);
        step(4'h0, 8'h00, 12'h1FF, 1'b0, 3'h0, 12'h000, 0);
        src_level = 8'h20;
        step(4'h0, 8'h00, 12'h200, 1'b1, 3'h5, 12'h006, 5);
        src_level = 8'h00;
        ret(12'h200, 16'h0000);
        drive(8'h80, 8'h00, 1'b0, 8'h00);
        step(4'h8, 8'h00, 12'h300, 1'b1, 3'h7, 12'h008, 9);
        ret(12'h300, 16'h0000);
        vector_table_select = 1'b1;
        app_section_lock_bit = 1'b1;
        drive(8'h10, 8'h00, 1'b0, 8'h00);
        step(4'h0, 8'h00, 12'h100, 1'b0, 3'h0, 12'h000, 0);
        app_section_lock_bit = 1'b0;
        step(4'h0, 8'h00, 12'h100, 1'b1, 3'h4, 12'hC05, 5);
        ret(12'h100, 16'h0000);
        vector_table_select = 1'b0;
        boot_section_lock_bit = 1'b1;
        drive(8'h10, 8'h00, 1'b0, 8'h00);
        step(4'h0, 8'h00, 12'hC10, 1'b0, 3'h0, 12'h000, 0);
        boot_section_lock_bit = 1'b0;
        step(4'h0, 8'h00, 12'hC10, 1'b1, 3'h4, 12'h005, 5);
        ret(12'hC10, 16'h0000);
        reset_vector_relocate_fuse = 1'b1;
        nrst = 1'b0;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        `CHK("relocated reset pc", 12'hC00, program_counter)
        `CHK("reset status", 8'h00, processor_status_reg)
        wrap_up();
    end
endmodule
